// ===== hw/adc_ctrl_map.vh
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// result word
`define WORD_BITS        18
`define WORD_MSB         17
`define ABORT_CODE       18'h3fc00
`define BITCNT_W         5
`define BITCNT_FULL      5'h11
`define BITCNT_ZERO      5'h00

// conversion timing
`define CLK_PERIOD_NS    20
`define CONV_TIME_NS     1160
`define CONV_CYCLES      ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W       16

// conversion states
`define ST_WAIT          2'h0
`define ST_SAMPLE        2'h1
`define ST_CONV          2'h2
`define ST_NAP           2'h3

// register byte offsets
`define OFS_CTRL         12'h000
`define OFS_SAMPLE       12'h004
`define OFS_STATUS       12'h008
`define OFS_COUNT        12'h00c
`define ADDR_W           12

// register fields and reset values
`define CTRL_RST         16'h003a
`define SAMPLE_RST       18'h00000
`define STAT_BUSY        0
`define STAT_ST_LO       1
`define STAT_ST_HI       2
`define STAT_ABORTED     3
`define STAT_FRAME       4
`define STAT_OE          5
`define STAT_LVL_LO      6
`define STAT_LVL_HI      7
`define CNT_HALF         16

// synchronised pin order
`define PIN_CONV         0
`define PIN_CS           1
`define PIN_FS           2
`define PIN_SCLK         3
`define PIN_FMT          4
`define PIN_PD           5
`define PIN_COUNT        6

`endif

// ===== hw/pin_sync.v
module pin_sync #(
    parameter W = 1
) (
    // clock
    input  wire         clk,
    input  wire         ce,
    // pins
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // no reset: the pins settle within two edges whatever the start
    always @(posedge clk) begin
        if (ce) begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // pin_sync

// ===== hw/result_buf.v
module result_buf #(
    parameter W = 19
) (
    // clock and reset
    input  wire         clk,
    input  wire         ce,
    input  wire         rst,
    // fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data,
    output wire [1:0]   level
);
    reg [W-1:0] head_r;
    reg [W-1:0] tail_r;
    reg [1:0]   cnt_r;
    reg [1:0]   cnt_nxt;
    wire        push;
    wire        pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = head_r;
    assign level     = cnt_r;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        cnt_nxt = cnt_r;
        if (push & ~pop)
            cnt_nxt = cnt_r + 2'h1;
        else if (pop & ~push)
            cnt_nxt = cnt_r - 2'h1;
    end

    always @(posedge clk) begin
        if (rst & ce) begin
            cnt_r  <= 2'h0;
            head_r <= {W{1'b0}};
            tail_r <= {W{1'b0}};
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            if (pop) begin
                head_r <= (cnt_r == 2'h2) ? tail_r : in_data;
                if (push & (cnt_r == 2'h2))
                    tail_r <= in_data;
            end else if (push) begin
                if (cnt_r == 2'h0)
                    head_r <= in_data;
                else
                    tail_r <= in_data;
            end
        end
    end
endmodule // result_buf

// ===== hw/sar_adc_serial_readout_ctrl.v
// The register addresses and the APB slave port were decided locally.
`include "adc_ctrl_map.vh"

module sar_adc_serial_readout_ctrl (
    // clock, enable, reset
    input  wire        CORE_CLK,
    input  wire        CE,
    input  wire        SYS_RST,
    // converter pins
    input  wire        CONV_TRIGGER_N,
    input  wire        CS_N,
    input  wire        FRAME_SYNC,
    input  wire        SCLK,
    input  wire        POWER_DOWN_IN,
    input  wire        OUTPUT_FORMAT_SEL,
    output reg         BUSY,
    output reg         SERIAL_DATA_OUT,
    output reg         SERIAL_DATA_OE,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR
);
    wire [`PIN_COUNT-1:0] pins_s;
    wire                  conv_s;
    wire                  cs_low;
    wire                  fs_s;
    wire                  sclk_s;
    wire                  fmt_s;
    wire                  pd_s;
    wire                  rst;

    reg         qual_r;
    reg         qual_prev_r;
    reg         cs_prev_r;
    reg         fs_prev_r;
    reg         sclk_prev_r;
    reg         busy_prev_r;
    wire        qual_fall;
    wire        cs_fall;
    wire        fs_rise;
    wire        sclk_rise;
    wire        sclk_fall;

    reg  [1:0]             state_r;
    reg  [1:0]             state_nxt;
    reg  [`CONV_CNT_W-1:0] conv_cnt_r;
    reg  [`CONV_CNT_W-1:0] conv_cnt_nxt;
    reg                    abort_req_r;
    reg                    aborted_r;
    wire                   cnt_done;
    wire                   sample_go;
    wire                   push_valid;
    wire                   push_ready;
    wire [`WORD_BITS:0]    push_data;

    wire                   buf_valid;
    wire [`WORD_BITS:0]    buf_data;
    wire [1:0]             buf_level;
    wire                   frame_start;
    wire                   busy_reload;
    wire                   load;
    wire [`WORD_BITS:0]    src_word;
    reg  [`WORD_BITS-1:0]  fmt_word;
    reg  [`WORD_BITS:0]    held_r;
    reg  [`WORD_BITS-1:0]  shift_r;
    reg  [`BITCNT_W-1:0]   bits_r;
    reg                    seen_fall_r;
    reg                    frame_r;

    reg  [`CONV_CNT_W-1:0] ctrl_r;
    reg  [`WORD_BITS-1:0]  sample_r;
    reg  [`CNT_HALF-1:0]   done_cnt_r;
    reg  [`CNT_HALF-1:0]   abort_cnt_r;
    wire                   apb_acc;
    wire                   apb_wr;
    reg  [31:0]            rd_nxt;
    reg                    err_nxt;

    // pins arrive from outside the core clock domain
    pin_sync #(
        .W (`PIN_COUNT)
    ) u_pin_sync (
        .clk (CORE_CLK),
        .ce  (CE),
        .d   ({POWER_DOWN_IN, OUTPUT_FORMAT_SEL, SCLK,
               FRAME_SYNC, CS_N, CONV_TRIGGER_N}),
        .q   (pins_s)
    );

    assign conv_s = pins_s[`PIN_CONV];
    assign cs_low = ~pins_s[`PIN_CS];
    assign fs_s   = pins_s[`PIN_FS];
    assign sclk_s = pins_s[`PIN_SCLK];
    assign fmt_s  = pins_s[`PIN_FMT];
    assign pd_s   = pins_s[`PIN_PD];
    assign rst    = SYS_RST | pd_s;

    // edge detection on synchronised pins
    always @(posedge CORE_CLK) begin
        if (rst & CE) begin
            qual_r      <= 1'b1;
            qual_prev_r <= 1'b1;
            cs_prev_r   <= 1'b0;
            fs_prev_r   <= 1'b0;
            sclk_prev_r <= 1'b0;
            busy_prev_r <= 1'b0;
        end else if (CE) begin
            if (cs_low)
                qual_r <= conv_s;
            qual_prev_r <= qual_r;
            cs_prev_r   <= cs_low;
            fs_prev_r   <= fs_s & cs_low;
            sclk_prev_r <= sclk_s;
            busy_prev_r <= BUSY;
        end
    end

    assign qual_fall = qual_prev_r & ~qual_r;
    assign cs_fall   = cs_low & ~cs_prev_r;
    assign fs_rise   = fs_s & cs_low & ~fs_prev_r;
    assign sclk_rise = cs_low & sclk_s & ~sclk_prev_r;
    assign sclk_fall = cs_low & ~sclk_s & sclk_prev_r;

    // conversion sequencing
    assign cnt_done   = (conv_cnt_r >= ctrl_r - 16'h0001);
    assign sample_go  = qual_r & cs_low;
    assign push_valid = (state_r == `ST_CONV) &
                        (cnt_done | abort_req_r | qual_fall);
    assign push_data  = (abort_req_r | qual_fall) ?
                        {1'b1, `ABORT_CODE} : {1'b0, sample_r};

    always @* begin
        state_nxt    = state_r;
        conv_cnt_nxt = conv_cnt_r;
        case (state_r)
            `ST_WAIT, `ST_NAP: begin
                if (sample_go)
                    state_nxt = `ST_SAMPLE;
            end
            `ST_SAMPLE: begin
                conv_cnt_nxt = {`CONV_CNT_W{1'b0}};
                if (qual_fall)
                    state_nxt = `ST_CONV;
            end
            `ST_CONV: begin
                // a full buffer holds the conversion, so busy stretches
                if (push_valid & push_ready) begin
                    if (abort_req_r | qual_fall)
                        state_nxt = `ST_WAIT;
                    else if (sample_go)
                        state_nxt = `ST_SAMPLE;
                    else if (~qual_r)
                        state_nxt = `ST_NAP;
                    else
                        state_nxt = `ST_WAIT;
                end else if (~cnt_done) begin
                    conv_cnt_nxt = conv_cnt_r + 16'h0001;
                end
            end
            default: begin
                state_nxt = `ST_WAIT;
            end
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (rst & CE) begin
            state_r     <= `ST_WAIT;
            conv_cnt_r  <= {`CONV_CNT_W{1'b0}};
            abort_req_r <= 1'b0;
            aborted_r   <= 1'b0;
            BUSY        <= 1'b0;
        end else if (CE) begin
            state_r    <= state_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            BUSY       <= (state_nxt == `ST_CONV);
            // keep an abort that meets a full buffer until it is stored
            if (push_valid & push_ready)
                abort_req_r <= 1'b0;
            else if ((state_r == `ST_CONV) & qual_fall)
                abort_req_r <= 1'b1;
            if (push_valid & push_ready)
                aborted_r <= push_data[`WORD_BITS];
        end
    end

    result_buf #(
        .W (`WORD_BITS + 1)
    ) u_result_buf (
        .clk       (CORE_CLK),
        .ce        (CE),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (buf_valid),
        .out_ready (frame_start),
        .out_data  (buf_data),
        .level     (buf_level)
    );

    // serial readout
    assign frame_start = (cs_fall & fs_s) | fs_rise;
    assign busy_reload = busy_prev_r & ~BUSY & fs_s & cs_low & buf_valid;
    assign load        = frame_start | busy_reload;
    assign src_word    = buf_valid ? buf_data : held_r;

    always @* begin
        if (src_word[`WORD_BITS])
            fmt_word = `ABORT_CODE;
        else if (fmt_s)
            fmt_word = src_word[`WORD_BITS-1:0] ^
                       {1'b1, {(`WORD_BITS-1){1'b0}}};
        else
            fmt_word = src_word[`WORD_BITS-1:0];
    end

    always @(posedge CORE_CLK) begin
        if (rst & CE) begin
            held_r          <= {(`WORD_BITS+1){1'b0}};
            shift_r         <= {`WORD_BITS{1'b0}};
            bits_r          <= `BITCNT_ZERO;
            seen_fall_r     <= 1'b0;
            frame_r         <= 1'b0;
            SERIAL_DATA_OUT <= 1'b0;
            SERIAL_DATA_OE  <= 1'b0;
        end else if (CE) begin
            SERIAL_DATA_OE <= cs_low;
            if (~cs_low) begin
                frame_r     <= 1'b0;
                seen_fall_r <= 1'b0;
            end else if (load) begin
                // a new frame aborts the running one
                if (buf_valid)
                    held_r <= buf_data;
                shift_r         <= fmt_word;
                SERIAL_DATA_OUT <= fmt_word[`WORD_MSB];
                bits_r          <= `BITCNT_FULL;
                seen_fall_r     <= 1'b0;
                frame_r         <= 1'b1;
            end else if (frame_r) begin
                if (sclk_fall)
                    seen_fall_r <= 1'b1;
                if (sclk_rise & seen_fall_r) begin
                    shift_r         <= {shift_r[`WORD_MSB-1:0], 1'b0};
                    SERIAL_DATA_OUT <= shift_r[`WORD_MSB-1];
                    if (bits_r != `BITCNT_ZERO)
                        bits_r <= bits_r - 5'h01;
                    else
                        frame_r <= 1'b0;
                end
            end
        end
    end

    // apb slave: one wait state, access completes on the second edge
    assign apb_acc = PSEL & PENABLE & ~PREADY;
    assign apb_wr  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

    always @* begin
        rd_nxt  = 32'h00000000;
        err_nxt = 1'b0;
        case (PADDR)
            `OFS_CTRL: begin
                rd_nxt[`CONV_CNT_W-1:0] = ctrl_r;
            end
            `OFS_SAMPLE: begin
                rd_nxt[`WORD_BITS-1:0] = sample_r;
            end
            `OFS_STATUS: begin
                rd_nxt[`STAT_BUSY]                 = BUSY;
                rd_nxt[`STAT_ST_HI:`STAT_ST_LO]    = state_r;
                rd_nxt[`STAT_ABORTED]              = aborted_r;
                rd_nxt[`STAT_FRAME]                = frame_r;
                rd_nxt[`STAT_OE]                   = SERIAL_DATA_OE;
                rd_nxt[`STAT_LVL_HI:`STAT_LVL_LO]  = buf_level;
            end
            `OFS_COUNT: begin
                rd_nxt = {abort_cnt_r, done_cnt_r};
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // control, sample and count registers survive power down (status fields do not); only the system reset
    // clears them, so software can still inspect what happened
    always @(posedge CORE_CLK) begin
        if (SYS_RST & CE) begin
            PRDATA      <= 32'h00000000;
            PREADY      <= 1'b0;
            PSLVERR     <= 1'b0;
            ctrl_r      <= `CTRL_RST;
            sample_r    <= `SAMPLE_RST;
            done_cnt_r  <= {`CNT_HALF{1'b0}};
            abort_cnt_r <= {`CNT_HALF{1'b0}};
        end else if (CE) begin
            PREADY <= apb_acc;
            if (apb_acc) begin
                PRDATA  <= PWRITE ? 32'h00000000 : rd_nxt;
                PSLVERR <= err_nxt;
            end else begin
                PRDATA  <= 32'h00000000;
                PSLVERR <= 1'b0;
            end
            if (apb_wr & (PADDR == `OFS_CTRL))
                ctrl_r <= (PWDATA[`CONV_CNT_W-1:0] == 16'h0000) ?
                          16'h0001 : PWDATA[`CONV_CNT_W-1:0];
            if (apb_wr & (PADDR == `OFS_SAMPLE))
                sample_r <= PWDATA[`WORD_BITS-1:0];
            if (push_valid & push_ready & ~pd_s) begin
                if (push_data[`WORD_BITS])
                    abort_cnt_r <= abort_cnt_r + 16'h0001;
                else
                    done_cnt_r <= done_cnt_r + 16'h0001;
            end
        end
    end
endmodule // sar_adc_serial_readout_ctrl

// ===== verification/adc_ctrl_properties.sv
module adc_ctrl_properties (
    // clock and reset
    input wire        CORE_CLK,
    input wire        SYS_RST,
    // converter pins
    input wire        CONV_TRIGGER_N,
    input wire        CS_N,
    input wire        POWER_DOWN_IN,
    input wire        BUSY,
    input wire        SERIAL_DATA_OUT,
    input wire        SERIAL_DATA_OE,
    // apb
    input wire        PSEL,
    input wire        PENABLE,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    // cycles since trigger was low with select low, saturating
    logic [3:0] trig_age_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST)
            trig_age_r <= 4'hf;
        else if (!CONV_TRIGGER_N && !CS_N)
            trig_age_r <= 4'h0;
        else if (trig_age_r != 4'hf)
            trig_age_r <= trig_age_r + 4'h1;
    end

    // pins pass a two-flop sync, so windows leave room for it
    sequence sel_idle;
        (CS_N && !POWER_DOWN_IN)[*8];
    endsequence
    sequence sel_active;
        (!CS_N && !POWER_DOWN_IN)[*8];
    endsequence
    sequence apb_access;
        PSEL && PENABLE && !PREADY;
    endsequence

    a_oe_on_select: assert property (sel_active |-> SERIAL_DATA_OE)
        else $error("output enable low while selected");
    a_oe_off_idle: assert property (sel_idle |-> !SERIAL_DATA_OE)
        else $error("output enable high while deselected");
    a_sdo_hold_idle: assert property (
        sel_idle |-> $stable(SERIAL_DATA_OUT))
        else $error("serial data moved while deselected");
    a_pd_quiets_all: assert property (POWER_DOWN_IN[*5] |->
        !BUSY && !SERIAL_DATA_OE)
        else $error("activity during power down");
    a_busy_needs_trig: assert property ($rose(BUSY) |-> trig_age_r <= 4'h8)
        else $error("busy rose without qualified trigger");
    a_apb_one_wait: assert property (apb_access |=> PREADY)
        else $error("apb answer late");
    a_pready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("pready longer than one cycle");
    a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer cycle");
    a_slverr_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule // adc_ctrl_properties

// ===== verification/adc_host_model.sv
module adc_host_model (
    // pacing clock
    input wire   clk,
    // device pins
    input wire   serial_data_out,
    input wire   oe,
    output logic cs_n,
    output logic conv_n,
    output logic fs,
    output logic sclk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_r;
    // a floating pin shows the inverse of what it last carried
    wire line = oe ? serial_data_out : ~last_r;

    initial begin
        cs_n = 1'b1;
        conv_n = 1'b1;
        fs = 1'b0;
        sclk = 1'b1;
        last_r = 1'b0;
    end
    always @(posedge clk) if (oe) last_r <= serial_data_out;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic trigger();
        conv_n <= 1'b0;
        wait_clk(6);
        conv_n <= 1'b1;
        wait_clk(6);
    endtask
    task automatic convert();
        cs_n <= 1'b0;
        wait_clk(6);
        trigger();
    endtask
    // select alone, no trigger and no frame
    task automatic select(input logic v);
        cs_n <= v;
        wait_clk(6);
    endtask
    // sync pulse while deselected must not start a frame
    task automatic stray_sync();
        cs_n <= 1'b1;
        fs <= 1'b1;
        wait_clk(6);
        fs <= 1'b0;
        wait_clk(6);
    endtask
    // sync pulse is one cycle so a late busy fall cannot reload
    task automatic frame(input bit by_sync, output logic [17:0] w);
        cs_n <= 1'b1;
        fs <= !by_sync;
        wait_clk(8);
        cs_n <= 1'b0;
        wait_clk(6);
        if (by_sync) begin
            fs <= 1'b1;
            wait_clk(1);
            fs <= 1'b0;
        end
        for (int i = 17; i >= 0; i--) begin
            sclk <= 1'b0;
            wait_clk(4);
            w[i] = line;
            sclk <= 1'b1;
            wait_clk(4);
        end
        cs_n <= 1'b1;
        fs <= 1'b0;
        wait_clk(8);
    endtask
endmodule // adc_host_model

// ===== verification/tb_sar_adc_serial_readout_ctrl.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_sar_adc_serial_readout_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, pd, fmt, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [17:0] w;
    wire         cs_n, conv_n, fs, sclk, busy, serial_data_out, oe, pready, pslverr;
    wire  [31:0] prdata;
    int          mismatches, checked;

    sar_adc_serial_readout_ctrl DUT (
        .CORE_CLK(clk), .CE(1'b1), .SYS_RST(rst),
        .CONV_TRIGGER_N(conv_n), .CS_N(cs_n), .FRAME_SYNC(fs),
        .SCLK(sclk), .POWER_DOWN_IN(pd), .OUTPUT_FORMAT_SEL(fmt),
        .BUSY(busy), .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OE(oe),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));
    adc_host_model host (
        .clk(clk), .serial_data_out(serial_data_out), .oe(oe), .cs_n(cs_n), .conv_n(conv_n),
        .fs(fs), .sclk(sclk));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_busy(input logic v);
        int n = 0;
        while (busy !== v && n < 3000) begin
            n++;
            @(posedge clk);
        end
        `CHK(busy, v)
    endtask

    task automatic t_regs();
        apb(0, 12'h000, 32'h0);
        `CHK(rd, 32'h0000003a)
        apb(0, 12'h010, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1, 12'h000, 32'h4);
        apb(0, 12'h000, 32'h0);
        `CHK(rd, 32'h00000004)
    endtask
    // sampling is entered, then the trigger falls with select high
    task automatic t_gate();
        host.select(1'b0);
        host.select(1'b1);
        host.trigger();
        `CHK(busy, 1'b0)
        apb(0, 12'h00c, 32'h0);
        `CHK(rd, 32'h00000000)
    endtask
    // two results fill the buffer, the third stalls until a pop
    task automatic t_buffer();
        apb(1, 12'h004, 32'h2a5c3);
        host.convert();
        wait_busy(1'b0);
        apb(1, 12'h004, 32'h15a3c);
        host.convert();
        wait_busy(1'b0);
        apb(1, 12'h004, 32'h3ffff);
        host.convert();
        host.wait_clk(40);
        `CHK(busy, 1'b1)
        host.stray_sync();
        host.frame(1, w);
        `CHK(w, 18'h2a5c3)
        wait_busy(1'b0);
        host.frame(0, w);
        `CHK(w, 18'h15a3c)
        fmt <= 1'b1;
        host.frame(0, w);
        `CHK(w, 18'h1ffff)
        fmt <= 1'b0;
    endtask
    task automatic t_abort();
        apb(1, 12'h000, 32'hc8);
        host.convert();
        `CHK(busy, 1'b1)
        host.trigger();
        `CHK(busy, 1'b0)
        fmt <= 1'b1;
        host.frame(0, w);
        `CHK(w, 18'h3fc00)
        fmt <= 1'b0;
        apb(0, 12'h00c, 32'h0);
        `CHK(rd, 32'h00010003)
    endtask
    task automatic t_pd();
        host.convert();
        pd <= 1'b1;
        host.wait_clk(10);
        `CHK({busy, oe}, 2'b00)
        pd <= 1'b0;
        host.wait_clk(10);
        `CHK(oe, 1'b1)
    endtask

    task automatic report_and_stop();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        mismatches = 0;
        checked = 0;
        rst = 1'b1;
        pd = 1'b0;
        fmt = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_gate();
        t_buffer();
        t_abort();
        t_pd();
        report_and_stop();
    end
endmodule // tb_sar_adc_serial_readout_ctrl

bind sar_adc_serial_readout_ctrl adc_ctrl_properties props (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .CONV_TRIGGER_N(CONV_TRIGGER_N), .CS_N(CS_N),
    .POWER_DOWN_IN(POWER_DOWN_IN), .BUSY(BUSY),
    .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OE(SERIAL_DATA_OE),
    .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
